// ### hdl/mcr_pkg.sv
// Package of offsets, field positions and reset values for the core register block
package mcr_pkg;
  localparam logic [7:0] OFS_STACK_TOP   = 8'h81;
  localparam logic [7:0] OFS_DATA_POINTER_WORD_LOW    = 8'h82;
  localparam logic [7:0] OFS_DATA_POINTER_WORD_HIGH   = 8'h83;
  localparam logic [7:0] OFS_PROG_CTRL   = 8'h87;
  localparam logic [7:0] OFS_CORE_CFG    = 8'hAF;
  localparam logic [7:0] OFS_STATUS_WORD = 8'hD0;
  localparam logic [7:0] OFS_ACCUM       = 8'hE0;
  localparam logic [7:0] RST_STACK_TOP   = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_WORD_BYTE   = 8'h00;
  localparam logic [7:0] RST_PROG_CTRL   = 8'h00;
  localparam logic [7:0] RST_CORE_CFG    = 8'h80;
  localparam logic [7:0] RST_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_ACCUM       = 8'h00;
  localparam logic [15:0] RST_FETCH_ADDR = 16'h0000;
  localparam logic [7:0] RST_OPCODE      = 8'h00;
  localparam int BIT_BAUD_DOUBLER   = 7;
  localparam int BIT_UART_ENHANCE   = 6;
  localparam int BIT_SYNC_PORT_SEL  = 5;
  localparam int BIT_MOD_ENABLE     = 4;
  localparam int BIT_XRAM_HI        = 1;
  localparam int BIT_XRAM_LO        = 0;
  localparam int BIT_BANK_HI        = 4;
  localparam int BIT_BANK_LO        = 3;
  localparam int BIT_PARITY         = 0;
  localparam int XRAM_MOVE_BYTES    = 256;
  localparam logic [1:0] CYC_REG_OP = 2'h1;
  localparam logic [1:0] CYC_MEM_OP = 2'h2;
  typedef enum logic [1:0] {
    MCR_FLOW_STEP = 2'b00,
    MCR_FLOW_LOAD = 2'b01,
    MCR_FLOW_HOLD = 2'b10
  } mcr_flow_t;
endpackage : mcr_pkg

// ### hdl/mcr_parity.sv
// Even parity generator for the accumulator
module mcr_parity
  import mcr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Data
  input  wire logic [WIDTH-1:0] data,
  // Parity bit making the total set-bit count even
  output      logic             parity
);
  assign parity = ^data;
endmodule // mcr_parity

// ### hdl/mcr_bank_file.sv
// Four banks of eight byte-wide working registers
module mcr_bank_file
  import mcr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // Access
  input  wire logic [1:0] bank_sel,
  input  wire logic [2:0] reg_idx,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Read data of the addressed register in the active bank
  output      logic [7:0] rd_data
);
  logic [7:0] bank_mem [32];
  wire  [4:0] flat_addr = {bank_sel, reg_idx};
  assign rd_data = bank_mem[flat_addr];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        bank_mem[i] <= 8'h00;
      end
    end else if (clk_en && wr_en) begin
      bank_mem[flat_addr] <= wr_data;
    end
  end
endmodule // mcr_bank_file

// ### hdl/mcr_core_regs.sv
// Basic core registers: fetch counter, opcode holder, banks, accumulator, pointers, config
module mcr_core_regs
  import mcr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Special function register access
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output      logic [7:0]  sfr_rdata,
  output      logic        sfr_hit,
  // Instruction flow from the sequencer
  input  wire logic        instr_done,
  input  wire logic [1:0]  instr_len,
  input  wire logic        branch_load,
  input  wire logic [15:0] branch_target,
  input  wire logic        opcode_load,
  input  wire logic [7:0]  opcode_in,
  // Working register and accumulator operations
  input  wire logic        acc_op_start,
  input  wire logic        acc_op_mem,
  input  wire logic [7:0]  acc_op_result,
  input  wire logic [2:0]  wreg_idx,
  input  wire logic        wreg_wr,
  input  wire logic [7:0]  wreg_wdata,
  output      logic [7:0]  wreg_rdata,
  // Architectural state
  output      logic [15:0] fetch_address_counter,
  output      logic [7:0]  opcode_holder,
  output      logic [7:0]  accum,
  output      logic [7:0]  status_word,
  output      logic [15:0] data_pointer_word,
  output      logic [7:0]  stack_top_pointer_reg,
  output      logic        acc_op_busy,
  // Configuration to peripherals
  output      logic        baud_doubler,
  output      logic        uart_enhance_enable,
  output      logic        sync_port_select,
  output      logic        modulation_enable,
  output      logic        external_move_enable
);
  logic [7:0]  data_pointer_low;
  logic [7:0]  data_pointer_high;
  logic [7:0]  program_control_reg;
  logic [7:0]  core_config_reg;
  logic [7:0]  status_hi;
  logic [1:0]  op_cnt;
  logic [7:0]  op_result;
  logic        parity_now;
  logic [7:0]  bank_rdata;
  mcr_flow_t   flow;

  // Decode of the special function space
  wire hit_sp   = (sfr_addr == OFS_STACK_TOP);
  wire hit_dpl  = (sfr_addr == OFS_DATA_POINTER_WORD_LOW);
  wire hit_dph  = (sfr_addr == OFS_DATA_POINTER_WORD_HIGH);
  wire hit_program_control_reg = (sfr_addr == OFS_PROG_CTRL);
  wire hit_cfg  = (sfr_addr == OFS_CORE_CFG);
  wire hit_psw  = (sfr_addr == OFS_STATUS_WORD);
  wire hit_acc  = (sfr_addr == OFS_ACCUM);
  wire any_hit  = hit_sp | hit_dpl | hit_dph | hit_program_control_reg | hit_cfg | hit_psw | hit_acc;
  wire wr_sp    = clk_en & sfr_wr & hit_sp;
  wire wr_dpl   = clk_en & sfr_wr & hit_dpl;
  wire wr_dph   = clk_en & sfr_wr & hit_dph;
  wire wr_program_control_reg  = clk_en & sfr_wr & hit_program_control_reg;
  wire wr_cfg   = clk_en & sfr_wr & hit_cfg;
  wire wr_psw   = clk_en & sfr_wr & hit_psw;
  wire wr_acc   = clk_en & sfr_wr & hit_acc;

  // Fetch counter has no software decode at all, only the flow inputs
  assign flow = branch_load ? MCR_FLOW_LOAD : (instr_done ? MCR_FLOW_STEP : MCR_FLOW_HOLD);
  wire [15:0] step_addr = fetch_address_counter + {14'h0000, instr_len};

  // One-cycle register ops finish at once; memory ops hold the accumulator a cycle
  wire        op_finish = (op_cnt == 2'h1);
  wire        reg_op_now = clk_en & acc_op_start & ~acc_op_mem & ~acc_op_busy;
  wire        mem_op_now = clk_en & acc_op_start & acc_op_mem & ~acc_op_busy;

  wire [7:0] rd_mux =
      hit_sp   ? stack_top_pointer_reg :
      hit_dpl  ? data_pointer_low :
      hit_dph  ? data_pointer_high :
      hit_program_control_reg ? program_control_reg :
      hit_cfg  ? core_config_reg :
      hit_psw  ? status_word :
      hit_acc  ? accum : 8'h00;

  mcr_parity #(
    .WIDTH (8)
  ) u_parity (
    .data   (accum),
    .parity (parity_now)
  );

  mcr_bank_file u_banks (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .bank_sel ({status_word[BIT_BANK_HI], status_word[BIT_BANK_LO]}),
    .reg_idx  (wreg_idx),
    .wr_en    (wreg_wr),
    .wr_data  (wreg_wdata),
    .rd_data  (bank_rdata)
  );

  // Status word with parity computed from the live accumulator
  assign status_word = {status_hi[7:1], parity_now};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_address_counter <= RST_FETCH_ADDR;
    end else if (clk_en) begin
      unique case (flow)
        MCR_FLOW_LOAD: fetch_address_counter <= branch_target;
        MCR_FLOW_STEP: fetch_address_counter <= step_addr;
        MCR_FLOW_HOLD: fetch_address_counter <= fetch_address_counter;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opcode_holder <= RST_OPCODE;
    end else if (clk_en && opcode_load) begin
      opcode_holder <= opcode_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_pointer_low  <= RST_DATA_POINTER_WORD_BYTE;
      data_pointer_high <= RST_DATA_POINTER_WORD_BYTE;
    end else begin
      if (wr_dpl) begin
        data_pointer_low <= sfr_wdata;
      end
      if (wr_dph) begin
        data_pointer_high <= sfr_wdata;
      end
    end
  end
  assign data_pointer_word = {data_pointer_high, data_pointer_low};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_top_pointer_reg <= RST_STACK_TOP;
    end else if (wr_sp) begin
      stack_top_pointer_reg <= sfr_wdata;
    end
  end

  // Reserved bits kept as storage so software sees its own writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      program_control_reg <= RST_PROG_CTRL;
      core_config_reg     <= RST_CORE_CFG;
    end else begin
      if (wr_program_control_reg) begin
        program_control_reg <= sfr_wdata;
      end
      if (wr_cfg) begin
        core_config_reg <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_hi <= RST_STATUS_WORD;
    end else if (wr_psw) begin
      status_hi <= sfr_wdata;
    end
  end

  // Accumulator: ALU result lands after one or two cycles; software write otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      accum       <= RST_ACCUM;
      op_cnt      <= 2'h0;
      op_result   <= 8'h00;
      acc_op_busy <= 1'b0;
    end else if (clk_en) begin
      if (reg_op_now) begin
        accum <= acc_op_result;
      end else if (mem_op_now) begin
        op_result   <= acc_op_result;
        op_cnt      <= CYC_MEM_OP - CYC_REG_OP;
        acc_op_busy <= 1'b1;
      end else if (acc_op_busy && op_finish) begin
        accum       <= op_result;
        op_cnt      <= 2'h0;
        acc_op_busy <= 1'b0;
      end else if (wr_acc) begin
        accum <= sfr_wdata;
      end
    end
  end

  // Registered outputs toward software and peripherals
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata            <= 8'h00;
      sfr_hit              <= 1'b0;
      wreg_rdata           <= 8'h00;
      baud_doubler         <= 1'b0;
      uart_enhance_enable  <= 1'b0;
      sync_port_select     <= 1'b0;
      modulation_enable    <= 1'b0;
      external_move_enable <= 1'b0;
    end else if (clk_en) begin
      sfr_rdata            <= sfr_rd ? rd_mux : 8'h00;
      sfr_hit              <= (sfr_rd | sfr_wr) & any_hit;
      wreg_rdata           <= bank_rdata;
      baud_doubler         <= program_control_reg[BIT_BAUD_DOUBLER];
      uart_enhance_enable  <= core_config_reg[BIT_UART_ENHANCE];
      sync_port_select     <= core_config_reg[BIT_SYNC_PORT_SEL];
      modulation_enable    <= core_config_reg[BIT_MOD_ENABLE];
      external_move_enable <= core_config_reg[BIT_XRAM_HI] | core_config_reg[BIT_XRAM_LO];
    end
  end

  a_sp_reset_value: assert property (@(posedge core_clk)
      $rose(rst_b) |-> stack_top_pointer_reg == RST_STACK_TOP)
    else $error("stack pointer reset value wrong");

  a_parity_even: assert property (@(posedge core_clk) disable iff (!rst_b)
      ^{accum, status_word[BIT_PARITY]} == 1'b0)
    else $error("accumulator parity not even");

  a_fetch_step: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && instr_done && !branch_load |=>
      fetch_address_counter == $past(fetch_address_counter) + 16'($past(instr_len)))
    else $error("fetch counter step wrong");

  a_fetch_branch: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && branch_load |=> fetch_address_counter == $past(branch_target))
    else $error("fetch counter branch load wrong");

  a_fetch_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      !branch_load && !instr_done |=> $stable(fetch_address_counter))
    else $error("fetch counter moved without cause");

  a_data_pointer_word_bytes: assert property (@(posedge core_clk) disable iff (!rst_b)
      wr_dpl |=> data_pointer_word[7:0] == $past(sfr_wdata) && $stable(data_pointer_word[15:8]))
    else $error("data pointer low write wrong");

  sequence s_mem_start;
    mem_op_now ##1 clk_en;
  endsequence
  sequence s_acc_hold;
    $stable(accum) ##1 (accum == $past(acc_op_result, 2));
  endsequence
  a_mem_op_two: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_mem_start |-> s_acc_hold)
    else $error("memory operand op timing wrong");

  // Busy lasts a single enabled cycle, so a refused start never stalls the core
  a_busy_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
      acc_op_busy && clk_en |=> !acc_op_busy)
    else $error("accumulator busy held too long");

  a_opcode_load: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && opcode_load |=> opcode_holder == $past(opcode_in))
    else $error("opcode holder load wrong");

  a_baud_copy: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en |=> baud_doubler == $past(program_control_reg[BIT_BAUD_DOUBLER]))
    else $error("baud doubler copy wrong");

  a_data_pointer_word_high_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
      wr_dph |=> data_pointer_word[15:8] == $past(sfr_wdata) && $stable(data_pointer_word[7:0]))
    else $error("data pointer high write wrong");

  a_reg_op_one: assert property (@(posedge core_clk) disable iff (!rst_b)
      reg_op_now |=> accum == $past(acc_op_result))
    else $error("register operand op timing wrong");

  a_xram_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en |=> external_move_enable == |$past(core_config_reg[1:0]))
    else $error("extended move enable wrong");

  a_port_select: assert property (@(posedge core_clk) disable iff (!rst_b)
      wr_cfg ##1 clk_en |=> sync_port_select == $past(sfr_wdata[BIT_SYNC_PORT_SEL], 2))
    else $error("sync port select wrong");
endmodule // mcr_core_regs

// ### dv/tb.sv
// Self-checking bench for the core register block
module tb
  import mcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk, rst_b, clk_en;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, opcode_in, acc_op_result;
  logic        sfr_wr, sfr_rd, sfr_hit, instr_done, branch_load, opcode_load;
  logic [1:0]  instr_len;
  logic [15:0] branch_target, fetch_address_counter, data_pointer_word;
  logic        acc_op_start, acc_op_mem, wreg_wr, acc_op_busy;
  logic [2:0]  wreg_idx;
  logic [7:0]  wreg_wdata, wreg_rdata, opcode_holder, accum, status_word;
  logic [7:0]  stack_top_pointer_reg;
  logic        baud_doubler, uart_enhance_enable, sync_port_select;
  logic        modulation_enable, external_move_enable;
  int          bad_count, checks_done;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic [15:0] exp_pc;

  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rstv; logic hit;} mcr_row_t;
  mcr_row_t rows [6] = '{
    '{OFS_STACK_TOP, 8'hA5, 8'h07, 1'b1}, '{OFS_DATA_POINTER_WORD_LOW, 8'h3C, 8'h00, 1'b1},
    '{OFS_DATA_POINTER_WORD_HIGH, 8'hC3, 8'h00, 1'b1}, '{OFS_PROG_CTRL, 8'h7F, 8'h00, 1'b1},
    '{OFS_CORE_CFG, 8'hAC, 8'h80, 1'b1}, '{8'h90, 8'h55, 8'h00, 1'b0}};
  logic [7:0] cfg_vals [7] = '{8'hC0, 8'hA0, 8'h90, 8'h81, 8'h82, 8'h83, 8'h8C};

  mcr_core_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .instr_done(instr_done),
    .instr_len(instr_len), .branch_load(branch_load), .branch_target(branch_target),
    .opcode_load(opcode_load), .opcode_in(opcode_in), .acc_op_start(acc_op_start),
    .acc_op_mem(acc_op_mem), .acc_op_result(acc_op_result), .wreg_idx(wreg_idx),
    .wreg_wr(wreg_wr), .wreg_wdata(wreg_wdata), .wreg_rdata(wreg_rdata),
    .fetch_address_counter(fetch_address_counter), .opcode_holder(opcode_holder),
    .accum(accum), .status_word(status_word), .data_pointer_word(data_pointer_word),
    .stack_top_pointer_reg(stack_top_pointer_reg), .acc_op_busy(acc_op_busy),
    .baud_doubler(baud_doubler), .uart_enhance_enable(uart_enhance_enable),
    .sync_port_select(sync_port_select), .modulation_enable(modulation_enable),
    .external_move_enable(external_move_enable));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Inputs move 1 ns after the rising edge, clear of the sampling instant
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // A spare cycle after each access keeps strobes from toggling twice in one step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask

  task automatic sfr_read(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    rd_val = sfr_rdata;
    rd_hit = sfr_hit;
    sfr_rd = 1'b0;
    tick;
  endtask

  task automatic wreg_access(input logic [2:0] i, input logic w, input logic [7:0] d);
    wreg_idx = i;
    wreg_wdata = d;
    wreg_wr = w;
    tick;
    wreg_wr = 1'b0;
    tick;
  endtask

  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end

  initial begin
    {rst_b, sfr_wr, sfr_rd, instr_done, branch_load, opcode_load} = '0;
    {acc_op_start, acc_op_mem, wreg_wr, instr_len, wreg_idx} = '0;
    {sfr_addr, sfr_wdata, opcode_in, acc_op_result, wreg_wdata, branch_target} = '0;
    clk_en = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    chk(fetch_address_counter, RST_FETCH_ADDR);
    chk(stack_top_pointer_reg, 8'h07);
    foreach (rows[k]) begin
      sfr_read(rows[k].addr);
      chk(rd_val, rows[k].rstv);
      chk(rd_hit, rows[k].hit);
    end
    foreach (rows[k]) begin
      sfr_write(rows[k].addr, rows[k].wdata);
      sfr_read(rows[k].addr);
      chk(rd_val, rows[k].hit ? rows[k].wdata : 8'h00);
      chk(rd_hit, rows[k].hit);
    end
    chk(data_pointer_word, 16'hC33C);
    chk(stack_top_pointer_reg, 8'hA5);
    chk(baud_doubler, 1'b0);
    sfr_write(OFS_PROG_CTRL, 8'h80);
    chk(baud_doubler, 1'b1);
    foreach (cfg_vals[k]) begin
      sfr_write(OFS_CORE_CFG, cfg_vals[k]);
      chk({uart_enhance_enable, sync_port_select, modulation_enable},
          cfg_vals[k][6:4]);
      chk(external_move_enable, cfg_vals[k][1] | cfg_vals[k][0]);
    end
    // Fetch counter steps by every legal length, then a branch beats a step
    exp_pc = 16'h0000;
    for (int len = 1; len <= 3; len++) begin
      instr_len = 2'(len);
      instr_done = 1'b1;
      tick;
      instr_done = 1'b0;
      exp_pc = exp_pc + 16'(len);
      chk(fetch_address_counter, exp_pc);
    end
    branch_target = 16'h1234;
    {branch_load, instr_done} = 2'b11;
    tick;
    {branch_load, instr_done, clk_en} = 3'b010;
    chk(fetch_address_counter, 16'h1234);
    tick;
    {instr_done, clk_en} = 2'b01;
    chk(fetch_address_counter, 16'h1234);
    opcode_in = 8'h5A;
    opcode_load = 1'b1;
    tick;
    opcode_load = 1'b0;
    chk(opcode_holder, 8'h5A);
    // Register operand: one edge; memory operand: two, with starts refused while busy
    acc_op_result = 8'h07;
    acc_op_start = 1'b1;
    tick;
    acc_op_mem = 1'b1;
    acc_op_result = 8'h03;
    chk(accum, 8'h07);
    chk(status_word[0], 1'b1);
    tick;
    acc_op_result = 8'hFF;
    chk(acc_op_busy, 1'b1);
    chk(accum, 8'h07);
    tick;
    acc_op_start = 1'b0;
    chk(accum, 8'h03);
    chk(status_word[0], 1'b0);
    tick;
    chk(accum, 8'h03);
    chk(acc_op_busy, 1'b0);
    sfr_write(OFS_ACCUM, 8'h0B);
    chk(accum, 8'h0B);
    chk(status_word[0], 1'b1);
    // Same index in each bank holds its own value
    for (int b = 0; b < 4; b++) begin
      sfr_write(OFS_STATUS_WORD, 8'(b << 3));
      wreg_access(3'h5, 1'b1, 8'(8'h10 + b));
    end
    for (int b = 3; b >= 0; b--) begin
      sfr_write(OFS_STATUS_WORD, 8'(b << 3));
      wreg_access(3'h5, 1'b0, 8'h00);
      chk(wreg_rdata, 8'(8'h10 + b));
    end
    // Reset in mid-run restores the stack, data pointer, fetch counter, config and baud doubler defaults
    rst_b = 1'b0;
    tick;
    chk(stack_top_pointer_reg, 8'h07);
    chk(data_pointer_word, 16'h0000);
    chk(baud_doubler, 1'b0);
    chk(fetch_address_counter, RST_FETCH_ADDR);
    rst_b = 1'b1;
    tick;
    sfr_read(OFS_CORE_CFG);
    chk(rd_val, RST_CORE_CFG);
    chk(uart_enhance_enable, 1'b0);
    sfr_read(OFS_STACK_TOP);
    chk(rd_val, 8'h07);
    tally_and_finish;
  end
endmodule // tb
